// file: src/edma_pkg.sv
// Constants, field layout and types of the four-channel DMA controller
package edma_pkg;
    localparam int NCH = 4;
    localparam int AW  = 16;

    // Global register offsets
    localparam logic [7:0] OFF_ISTAT = 8'h00;
    localparam logic [7:0] OFF_IMASK = 8'h04;
    localparam logic [7:0] OFF_STAT  = 8'h08;
    // Channel c sits in address group CH_BASE_GRP + c, at 8'h10 + c * 16
    localparam logic [3:0] CH_BASE_GRP = 4'h1;
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_SRC     = 4'h4;
    localparam logic [3:0] OFF_DST     = 4'h8;
    localparam logic [3:0] OFF_CNT     = 4'hc;

    // Channel control fields
    localparam int C_EN     = 0;
    localparam int C_BURST2 = 1;
    localparam int C_REP    = 2;
    localparam int C_SINC   = 3;
    localparam int C_DINC   = 4;
    localparam int C_SRLD   = 5;
    localparam int C_DRLD   = 7;
    localparam int C_TRIG   = 9;
    localparam int C_SWREQ  = 11;
    localparam int C_LINK   = 12;
    localparam int C_MATCH  = 13;
    localparam int C_CRC    = 14;
    localparam int C_STD    = 15;
    // Count register fields
    localparam int CNT_MVAL = 16;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0]  IRQ_RST  = 8'h00;

    // Reload points
    localparam logic [1:0] RLD_NONE  = 2'h0;
    localparam logic [1:0] RLD_BURST = 2'h1;
    localparam logic [1:0] RLD_BLOCK = 2'h2;
    localparam logic [1:0] RLD_TRANS = 2'h3;
    // Trigger sources
    localparam logic [1:0] TRIG_SW     = 2'h0;
    localparam logic [1:0] TRIG_PERIPH = 2'h1;
    localparam logic [1:0] TRIG_EVENT  = 2'h2;

    // Read-only memory window
    localparam logic [15:0] EE_BASE = 16'h1000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD,
        ST_RWAIT,
        ST_WR
    } edma_state_t;
endpackage : edma_pkg

// file: src/edma_sync.sv
// Two-stage synchroniser for trigger inputs
`timescale 1ns/100ps
module edma_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : edma_sync

// file: src/edma_top.sv
// Four-channel DMA controller: registers, channels and transfer engine
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
module edma_top #(
    parameter int unsigned EE_SIZE = 1024
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Trigger inputs
    input  wire logic [3:0]  periph_req_i,
    input  wire logic [3:0]  event_i,
    // Memory and peripheral bus master
    output logic      [15:0] mem_addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [7:0]  mem_wdata_o,
    input  wire logic [7:0]  mem_rdata_i,
    input  wire logic        mem_rvalid_i,
    // Checksum feed
    output logic      [7:0]  crc_data_o,
    output logic             crc_valid_o,
    // Interrupt
    output logic             irq_o
);
    localparam int N = edma_pkg::NCH;

    function automatic logic [1:0] pick(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : pick

    function automatic logic [16:0] blk_len(input logic [15:0] v);
        return {(v == 16'h0000), v};
    endfunction : blk_len

    function automatic logic reload(input logic [1:0] m, input logic bu,
                                    input logic bl, input logic tr);
        return (m == edma_pkg::RLD_BURST && bu) ||
               (m == edma_pkg::RLD_BLOCK && bl) ||
               (m == edma_pkg::RLD_TRANS && tr);
    endfunction : reload

    function automatic logic in_ee(input logic [15:0] a);
        return (a >= edma_pkg::EE_BASE) &&
               ({1'b0, a} < {1'b0, edma_pkg::EE_BASE} + 17'(EE_SIZE));
    endfunction : in_ee

    // Channel state
    logic [15:0] ctrl_q   [N];
    logic [15:0] ctrl_d   [N];
    logic [15:0] sbase_q  [N];
    logic [15:0] sbase_d  [N];
    logic [15:0] dbase_q  [N];
    logic [15:0] dbase_d  [N];
    logic [15:0] src_q    [N];
    logic [15:0] src_d    [N];
    logic [15:0] dst_q    [N];
    logic [15:0] dst_d    [N];
    logic [15:0] blk_q    [N];
    logic [15:0] blk_d    [N];
    logic [7:0]  mval_q   [N];
    logic [7:0]  mval_d   [N];
    logic [16:0] left_q   [N];
    logic [16:0] left_d   [N];
    logic [3:0]  rep_q;
    logic [3:0]  rep_d;
    logic [3:0]  busy_q;
    logic [3:0]  busy_d;
    logic [3:0]  pend_q;
    logic [3:0]  pend_d;
    logic [7:0]  trg_prev_q;
    logic [7:0]  trg_prev_d;
    logic [7:0]  istat_q;
    logic [7:0]  istat_d;
    logic [7:0]  imask_q;
    logic [7:0]  imask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Engine state
    edma_pkg::edma_state_t st_q;
    edma_pkg::edma_state_t st_d;
    logic [1:0]  ach_q;
    logic [1:0]  ach_d;
    logic        nb_q;
    logic        nb_d;
    logic [7:0]  dat_q;
    logic [7:0]  dat_d;
    logic [7:0]  crc_q;
    logic [7:0]  crc_d;
    logic        crcv_q;
    logic        crcv_d;

    // Engine events and decode
    logic [7:0]  trg_sync;
    logic [7:0]  trg_rise;
    logic [3:0]  elig;
    logic [15:0] actl;
    logic        std_a;
    logic        byte_done;
    logic        err_ev;
    logic        hit;
    logic        last;
    logic        blk_end;
    logic        trans_end;
    logic        ch_ok;
    logic [1:0]  ch_sel;
    logic [3:0]  ch_off;

    edma_sync #(
        .W (8)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({event_i, periph_req_i}),
        .sync_o    (trg_sync)
    );

    assign trg_rise = trg_sync & ~trg_prev_q;
    assign ch_ok    = reg_addr_i[7:4] >= edma_pkg::CH_BASE_GRP &&
                      reg_addr_i[7:4] < edma_pkg::CH_BASE_GRP + 4'(N) &&
                      reg_addr_i[1:0] == 2'h0;
    assign ch_sel   = 2'(reg_addr_i[7:4] - edma_pkg::CH_BASE_GRP);
    assign ch_off   = reg_addr_i[3:0];

    // Odd partner is absorbed by a standard channel
    always_comb begin
        for (int c = 0; c < N; c++) begin
            elig[c] = pend_q[c] & busy_q[c] &
                      ~((c % 2 == 1) && ctrl_q[c - (c % 2)][edma_pkg::C_STD]);
        end
    end

    assign actl  = ctrl_q[ach_q];
    assign std_a = ~ach_q[0] & actl[edma_pkg::C_STD];
    // Standard channel searches what it reads, peripheral matches what it moves
    assign hit   = actl[edma_pkg::C_MATCH] &&
                   ((std_a ? mem_rdata_i : dat_q) == mval_q[ach_q]);
    assign last  = hit || left_q[ach_q] == 17'd1 ||
                   nb_q == actl[edma_pkg::C_BURST2];
    assign blk_end   = left_q[ach_q] == 17'd1;
    assign trans_end = hit || (blk_end &&
                       (~actl[edma_pkg::C_REP] || rep_q[ach_q]));

    // Transfer engine: one channel owns the bus until its burst ends
    always_comb begin
        st_d      = st_q;
        ach_d     = ach_q;
        nb_d      = nb_q;
        dat_d     = dat_q;
        crc_d     = crc_q;
        crcv_d    = 1'b0;
        byte_done = 1'b0;
        err_ev    = 1'b0;
        mem_rd_o  = 1'b0;
        mem_wr_o  = 1'b0;
        case (st_q)
            edma_pkg::ST_IDLE: begin
                if (elig != 4'h0) begin
                    ach_d = pick(elig);
                    nb_d  = 1'b0;
                    st_d  = edma_pkg::ST_RD;
                end
            end
            edma_pkg::ST_RD: begin
                mem_rd_o = 1'b1;
                st_d     = edma_pkg::ST_RWAIT;
            end
            edma_pkg::ST_RWAIT: begin
                // Slow memory answers later; wait for its valid
                if (mem_rvalid_i) begin
                    dat_d = mem_rdata_i;
                    if (actl[edma_pkg::C_CRC]) begin
                        crc_d  = mem_rdata_i;
                        crcv_d = 1'b1;
                    end
                    if (std_a) begin
                        byte_done = 1'b1;
                        nb_d      = ~nb_q;
                        st_d      = last ? edma_pkg::ST_IDLE
                                         : edma_pkg::ST_RD;
                    end else begin
                        st_d = edma_pkg::ST_WR;
                    end
                end
            end
            edma_pkg::ST_WR: begin
                if (in_ee(dst_q[ach_q])) begin
                    err_ev = 1'b1;
                    st_d   = edma_pkg::ST_IDLE;
                end else begin
                    mem_wr_o  = 1'b1;
                    byte_done = 1'b1;
                    nb_d      = ~nb_q;
                    st_d      = last ? edma_pkg::ST_IDLE
                                     : edma_pkg::ST_RD;
                end
            end
            default: begin
                st_d = edma_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q   <= edma_pkg::ST_IDLE;
            ach_q  <= 2'h0;
            nb_q   <= 1'b0;
            dat_q  <= 8'h00;
            crc_q  <= 8'h00;
            crcv_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            ach_q  <= ach_d;
            nb_q   <= nb_d;
            dat_q  <= dat_d;
            crc_q  <= crc_d;
            crcv_q <= crcv_d;
        end
    end

    // Channels, interrupts, registers
    always_comb begin
        logic [1:0] nx;
        logic       bu;
        logic [7:0] iset;
        logic [7:0] iclr;
        nx         = 2'(ach_q + 2'h1);
        bu         = byte_done & last;
        iset       = 8'h00;
        iclr       = 8'h00;
        rep_d      = rep_q;
        busy_d     = busy_q;
        pend_d     = pend_q;
        trg_prev_d = trg_sync;
        imask_d    = imask_q;
        rdata_d    = 32'h0000_0000;
        for (int c = 0; c < N; c++) begin
            ctrl_d[c]  = ctrl_q[c];
            sbase_d[c] = sbase_q[c];
            dbase_d[c] = dbase_q[c];
            src_d[c]   = src_q[c];
            dst_d[c]   = dst_q[c];
            blk_d[c]   = blk_q[c];
            mval_d[c]  = mval_q[c];
            left_d[c]  = left_q[c];
            // Register writes per channel
            if (reg_wr_i && ch_ok && ch_sel == 2'(c)) begin
                case (ch_off)
                    edma_pkg::OFF_CTRL: begin
                        ctrl_d[c] = reg_wdata_i[15:0];
                        ctrl_d[c][edma_pkg::C_SWREQ] = 1'b0;
                        busy_d[c] = reg_wdata_i[edma_pkg::C_EN];
                        pend_d[c] = reg_wdata_i[edma_pkg::C_EN] &
                                    reg_wdata_i[edma_pkg::C_SWREQ];
                        if (reg_wdata_i[edma_pkg::C_EN] && !busy_q[c]) begin
                            src_d[c]  = sbase_q[c];
                            dst_d[c]  = dbase_q[c];
                            left_d[c] = blk_len(blk_q[c]);
                            rep_d[c]  = 1'b0;
                        end
                    end
                    edma_pkg::OFF_SRC: begin
                        sbase_d[c] = reg_wdata_i[15:0];
                        src_d[c]   = reg_wdata_i[15:0];
                    end
                    edma_pkg::OFF_DST: begin
                        dbase_d[c] = reg_wdata_i[15:0];
                        dst_d[c]   = reg_wdata_i[15:0];
                    end
                    edma_pkg::OFF_CNT: begin
                        blk_d[c]  = reg_wdata_i[15:0];
                        mval_d[c] = reg_wdata_i[edma_pkg::CNT_MVAL +: 8];
                    end
                    default: begin
                    end
                endcase
            end
            // Byte moved by the engine on this channel
            if (byte_done && ach_q == 2'(c)) begin
                if (ctrl_q[c][edma_pkg::C_SINC]) begin
                    src_d[c] = src_q[c] + 16'h0001;
                end
                if (ctrl_q[c][edma_pkg::C_DINC]) begin
                    dst_d[c] = dst_q[c] + 16'h0001;
                end
                left_d[c] = left_q[c] - 17'd1;
                if (blk_end && !trans_end) begin
                    rep_d[c]  = 1'b1;
                    left_d[c] = blk_len(blk_q[c]);
                end
                if (reload(ctrl_q[c][edma_pkg::C_SRLD +: 2], bu, blk_end,
                           trans_end)) begin
                    src_d[c] = sbase_q[c];
                end
                if (reload(ctrl_q[c][edma_pkg::C_DRLD +: 2], bu, blk_end,
                           trans_end)) begin
                    dst_d[c] = dbase_q[c];
                end
                if (bu && ctrl_q[c][edma_pkg::C_TRIG +: 2] !=
                          edma_pkg::TRIG_SW) begin
                    pend_d[c] = 1'b0;
                end
                if (trans_end) begin
                    busy_d[c] = 1'b0;
                    pend_d[c] = 1'b0;
                    ctrl_d[c][edma_pkg::C_EN] = 1'b0;
                    iset[c]   = 1'b1;
                end
            end
            if (err_ev && ach_q == 2'(c)) begin
                busy_d[c] = 1'b0;
                pend_d[c] = 1'b0;
                ctrl_d[c][edma_pkg::C_EN] = 1'b0;
                iset[c + N] = 1'b1;
            end
            // Hardware triggers take one burst each; a set beats the burst-end clear but not the transfer-end clear
            if (busy_d[c] &&
                ((ctrl_q[c][edma_pkg::C_TRIG +: 2] == edma_pkg::TRIG_PERIPH &&
                  trg_rise[c]) ||
                 (ctrl_q[c][edma_pkg::C_TRIG +: 2] == edma_pkg::TRIG_EVENT &&
                  trg_rise[c + N]))) begin
                pend_d[c] = 1'b1;
            end
        end
        // Linked successor takes over
        if (byte_done && trans_end && actl[edma_pkg::C_LINK]) begin
            busy_d[nx] = 1'b1;
            pend_d[nx] = 1'b1;
            ctrl_d[nx][edma_pkg::C_EN] = 1'b1;
            src_d[nx]  = sbase_q[nx];
            dst_d[nx]  = dbase_q[nx];
            left_d[nx] = blk_len(blk_q[nx]);
            rep_d[nx]  = 1'b0;
        end
        if (reg_wr_i && reg_addr_i == edma_pkg::OFF_ISTAT) begin
            iclr = reg_wdata_i[7:0];
        end
        if (reg_wr_i && reg_addr_i == edma_pkg::OFF_IMASK) begin
            imask_d = reg_wdata_i[7:0];
        end
        istat_d = (istat_q & ~iclr) | iset;
        if (reg_rd_i) begin
            if (ch_ok) begin
                case (ch_off)
                    edma_pkg::OFF_CTRL: rdata_d = {16'h0000, ctrl_q[ch_sel]};
                    edma_pkg::OFF_SRC:  rdata_d = {16'h0000, src_q[ch_sel]};
                    edma_pkg::OFF_DST:  rdata_d = {16'h0000, dst_q[ch_sel]};
                    edma_pkg::OFF_CNT:  rdata_d = {8'h00, mval_q[ch_sel],
                                                   blk_q[ch_sel]};
                    default:            rdata_d = 32'h0000_0000;
                endcase
            end else if (reg_addr_i == edma_pkg::OFF_ISTAT) begin
                rdata_d = {24'h000000, istat_q};
            end else if (reg_addr_i == edma_pkg::OFF_IMASK) begin
                rdata_d = {24'h000000, imask_q};
            end else if (reg_addr_i == edma_pkg::OFF_STAT) begin
                rdata_d = {24'h000000, pend_q, busy_q};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int c = 0; c < N; c++) begin
                ctrl_q[c]  <= edma_pkg::CTRL_RST;
                sbase_q[c] <= edma_pkg::ADDR_RST;
                dbase_q[c] <= edma_pkg::ADDR_RST;
                src_q[c]   <= edma_pkg::ADDR_RST;
                dst_q[c]   <= edma_pkg::ADDR_RST;
                blk_q[c]   <= 16'h0000;
                mval_q[c]  <= 8'h00;
                left_q[c]  <= 17'h00000;
            end
            rep_q      <= 4'h0;
            busy_q     <= 4'h0;
            pend_q     <= 4'h0;
            trg_prev_q <= 8'h00;
            istat_q    <= edma_pkg::IRQ_RST;
            imask_q    <= edma_pkg::IRQ_RST;
            rdata_q    <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < N; c++) begin
                ctrl_q[c]  <= ctrl_d[c];
                sbase_q[c] <= sbase_d[c];
                dbase_q[c] <= dbase_d[c];
                src_q[c]   <= src_d[c];
                dst_q[c]   <= dst_d[c];
                blk_q[c]   <= blk_d[c];
                mval_q[c]  <= mval_d[c];
                left_q[c]  <= left_d[c];
            end
            rep_q      <= rep_d;
            busy_q     <= busy_d;
            pend_q     <= pend_d;
            trg_prev_q <= trg_prev_d;
            istat_q    <= istat_d;
            imask_q    <= imask_d;
            rdata_q    <= rdata_d;
        end
    end

    // Source address to read, destination to write
    assign mem_addr_o  = (st_q == edma_pkg::ST_WR) ? dst_q[ach_q]
                                                   : src_q[ach_q];
    assign mem_wdata_o = dat_q;
    assign crc_data_o  = crc_q;
    assign crc_valid_o = crcv_q;
    assign reg_rdata_o = rdata_q;
    assign irq_o       = |(istat_q & imask_q);
endmodule : edma_top

// file: testbench/edma_mem_model.sv
// Byte memory standing on the controller's bus
`timescale 1ns/100ps
module edma_mem_model (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // Bus from the controller
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        mem_rd_i,
    input  wire logic        mem_wr_i,
    input  wire logic [7:0]  mem_wdata_i,
    input  wire logic        slow_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_q;
    logic [1:0]  wait_q;
    logic        pend_q;
    logic [1:0]  lat;
    // Read-only window adds one cycle of latency and slow_i adds another
    assign lat = 2'(mem_addr_i[15:12] == 4'h1) + 2'(slow_i);
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q   <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o  <= 8'h5a;
        end else begin
            rvalid_o <= 1'b0;
            // Stale data toggles so it is never mistaken for an answer
            rdata_o  <= ~rdata_o;
            if (mem_wr_i)
                mem[mem_addr_i] <= mem_wdata_i;
            if (mem_rd_i && lat == 2'h0) begin
                rvalid_o <= 1'b1;
                rdata_o  <= mem[mem_addr_i];
            end else if (mem_rd_i) begin
                pend_q <= 1'b1;
                addr_q <= mem_addr_i;
                wait_q <= lat - 2'h1;
            end else if (pend_q && wait_q == 2'h0) begin
                pend_q   <= 1'b0;
                rvalid_o <= 1'b1;
                rdata_o  <= mem[addr_q];
            end else if (pend_q)
                wait_q <= wait_q - 2'h1;
        end
    end
endmodule : edma_mem_model

// file: testbench/edma_props.sv
// Port assertions of the DMA controller
`timescale 1ns/100ps
module edma_props #(
    parameter int unsigned EE_SIZE = 1024
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    // Register port
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Memory bus and checksum
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        mem_rvalid_i,
    input wire logic [7:0]  crc_data_o,
    input wire logic        crc_valid_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_rd_one_cycle: assert property (mem_rd_o |=> !mem_rd_o)
        else $error("read held");
    a_rd_wr_apart: assert property (!(mem_rd_o && mem_wr_o))
        else $error("rd and wr");
    a_wait_before_wr: assert property (mem_rd_o |=> !mem_wr_o)
        else $error("early write");
    a_src_addr_hold: assert property (mem_rd_o |=> $stable(mem_addr_o))
        else $error("address moved");
    a_wr_moves_data: assert property (mem_wr_o |->
        $past(mem_rvalid_i) && mem_wdata_o == $past(mem_rdata_i))
        else $error("wrong write data");
    a_wr_single: assert property (mem_wr_o |=> !mem_wr_o)
        else $error("write held");
    a_ro_no_write: assert property (mem_wr_o |->
        mem_addr_o < edma_pkg::EE_BASE
        || mem_addr_o >= edma_pkg::EE_BASE + EE_SIZE)
        else $error("read-only write");
    a_crc_follows: assert property (crc_valid_o |->
        $past(mem_rvalid_i) && crc_data_o == $past(mem_rdata_i))
        else $error("wrong checksum byte");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
        else $error("stale read data");
endmodule : edma_props

bind edma_top edma_props #(.EE_SIZE(EE_SIZE)) edma_props_inst (
    .ref_clk_i, .reset_n_i, .reg_rd_i, .reg_rdata_o, .mem_addr_o,
    .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i, .mem_rvalid_i,
    .crc_data_o, .crc_valid_o
);

// file: testbench/edma_top_bench.sv
// Self-checking bench of the DMA controller
`timescale 1ns/100ps
module edma_top_bench;
    localparam logic [31:0] K_SW = (32'h1 << edma_pkg::C_EN)
                                 | (32'h1 << edma_pkg::C_SWREQ);
    localparam logic [31:0] K_SI = 32'h1 << edma_pkg::C_SINC;
    localparam logic [31:0] K_DI = 32'h1 << edma_pkg::C_DINC;
    logic        ref_clk_i, reset_n_i, reg_wr_i, reg_rd_i;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv;
    logic [3:0]  periph_req_i, event_i;
    logic [15:0] mem_addr_o;
    logic        mem_rd_o, mem_wr_o, mem_rvalid_i, crc_valid_o, irq_o;
    logic [7:0]  mem_wdata_o, mem_rdata_i, crc_data_o;
    logic        slow;
    logic [7:0]  src_b [0:4];
    logic [7:0]  adr [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                               8'h20, 8'h30, 8'h40, 8'hf0};
    int          fails, checks, cyc, crcs, seed;

    edma_top #(.EE_SIZE(1024)) edma_top_inst (
        .ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .periph_req_i, .event_i, .mem_addr_o,
        .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i, .mem_rvalid_i,
        .crc_data_o, .crc_valid_o, .irq_o);
    edma_mem_model edma_mem_model_inst (
        .ref_clk_i, .reset_n_i, .mem_addr_i(mem_addr_o),
        .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o),
        .slow_i(slow), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i));

    function automatic int blk_idx(input int i, input int n);
        return i % n; // Block reload brings the source back to its start
    endfunction : blk_idx
    function automatic logic [31:0] mb(input logic [15:0] a);
        return {24'h0, edma_mem_model_inst.mem[a]};
    endfunction : mb
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic cmp(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    task automatic start(input int c, input logic [31:0] ctl,
                         input logic [15:0] s, d, n);
        logic [7:0] b;
        b = 8'h10 + 8'(c * 16);
        wr(b + 8'h4, {16'h0, s});
        wr(b + 8'h8, {16'h0, d});
        wr(b + 8'hc, {16'h0, n});
        wr(b, ctl);
    endtask : start
    task automatic wait_ist(input logic [31:0] m);
        int k;
        k  = 0;
        rv = 0;
        while ((rv & m) == 0 && k < 200) begin
            rd(edma_pkg::OFF_ISTAT, rv);
            k++;
        end
    endtask : wait_ist
    task automatic pulse(input int c, input logic ev);
        @(posedge ref_clk_i);
        if (ev) event_i[c] <= 1'b1;
        else periph_req_i[c] <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        event_i      <= 4'h0;
        periph_req_i <= 4'h0;
        repeat (10) @(posedge ref_clk_i);
    endtask : pulse

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (crc_valid_o === 1'b1) crcs++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        {fails, checks, cyc, crcs, seed} = {128'h0, 32'h180ad4eb};
        {reset_n_i, reg_wr_i, reg_rd_i, slow} = 4'h0;
        {reg_addr_i, reg_wdata_i, periph_req_i, event_i} = 48'h0;
        repeat (4) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(adr[i], rv);
            cmp("reset value", 32'h0, rv);
        end
        $display("test reset done");
        wr(edma_pkg::OFF_IMASK, 32'h0000_0011);
        for (int i = 0; i < 5; i++) begin
            src_b[i] = 8'($random(seed));
            edma_mem_model_inst.mem[16'h0100 + 16'(i)] = src_b[i];
        end
        start(0, K_SW | K_SI | K_DI, 16'h0100, 16'h0200, 16'd5);
        wait_ist(32'h1);
        for (int i = 0; i < 5; i++)
            cmp("copy", {24'h0, src_b[i]}, mb(16'h0200 + 16'(i)));
        cmp("done flag", 32'h1, rv);
        cmp("irq", 32'h1, {31'h0, irq_o});
        rd(edma_pkg::OFF_STAT, rv);
        cmp("busy", 32'h0, rv & 32'hf);
        wr(edma_pkg::OFF_ISTAT, 32'h1);
        rd(edma_pkg::OFF_ISTAT, rv);
        cmp("flag clear", 32'h0, rv);
        cmp("irq low", 32'h0, {31'h0, irq_o});
        $display("test copy done");
        slow = 1'b1;
        crcs = 0;
        start(1, K_SW | K_SI | K_DI | (32'h1 << edma_pkg::C_BURST2)
              | (32'h1 << edma_pkg::C_REP) | (32'h1 << edma_pkg::C_CRC)
              | (32'(edma_pkg::RLD_BLOCK) << edma_pkg::C_SRLD),
              16'h0100, 16'h0400, 16'd2);
        wait_ist(32'h2);
        for (int i = 0; i < 4; i++)
            cmp("repeat", {24'h0, src_b[blk_idx(i, 2)]},
                mb(16'h0400 + 16'(i)));
        cmp("crc bytes", 32'd4, 32'(crcs));
        wr(edma_pkg::OFF_ISTAT, 32'hff);
        $display("test repeat done");
        edma_mem_model_inst.mem[16'h1004] = 8'h77;
        start(2, K_SW | K_SI, edma_pkg::EE_BASE, 16'h1004, 16'd1);
        wait_ist(32'h40);
        cmp("error flag", 32'h40, rv);
        cmp("ro kept", 32'h77, mb(16'h1004));
        wr(edma_pkg::OFF_ISTAT, 32'hff);
        $display("test refuse done");
        slow = 1'b0;
        start(3, (32'h1 << edma_pkg::C_EN) | K_SI
              | (32'(edma_pkg::TRIG_PERIPH) << edma_pkg::C_TRIG),
              16'h0100, 16'h0700, 16'd3);
        for (int k = 0; k < 3; k++) begin
            pulse(3, 1'b0);
            rd(edma_pkg::OFF_ISTAT, rv);
            cmp("per burst", k == 2 ? 32'h8 : 32'h0, rv);
        end
        cmp("static dst", {24'h0, src_b[2]}, mb(16'h0700));
        start(0, (32'h1 << edma_pkg::C_EN)
              | (32'(edma_pkg::TRIG_EVENT) << edma_pkg::C_TRIG),
              16'h0101, 16'h0701, 16'd1);
        pulse(0, 1'b1);
        wait_ist(32'h1);
        cmp("event", {24'h0, src_b[1]}, mb(16'h0701));
        $display("test trigger done");
        final_report();
    end
endmodule : edma_top_bench
